// ### sep_dev.sv
// Purpose: Two-wire EEPROM slave: addressing, byte and page writes.
// Assumes: link_clk_i oversamples the bus; sys_clk_i times programming.
// Notes: A small read path exists so a master can send a NACK.
// Overview of operation
// - Transmitter floats; receiver pulls low for ACK.
// - Master NACK ends read; device releases data.
// - Acknowledging party releases line after ninth clock.
// - Standby after reset, plain Stop, write done.
// - Master recovers bus within nine clocks, Start.
// - Array is 256 pages of 32 bytes.
// - Upper address nibble must equal type pattern.
// - Bits three to one match the straps.
// - Address bit zero selects read or write.
// - ACK matching address, NACK any other.
// - Master sends two word address bytes.
// - First byte gives top five address bits.
// - Second byte gives low eight address bits.
// - Byte write acked; Stop starts write cycle.
// - Bus ignored while write cycle runs.
// - Page write takes one to 32 bytes.
// - Every page data byte acked; Stop programs.
// - Only low five address bits increment, wrap.
// - Master avoids overrunning the page end.
// - Address NACKed during write, then acked.
// - Protected top quarter: acked, never programmed.
`timescale 1ns/1ps
module sep_dev #(
    parameter int WR_CYCLES = sep_pkg::WR_CYCLES
) (
    // Clocks and reset
    input wire logic sys_clk_i,
    input wire logic link_clk_i,
    input wire logic rst_b_i,
    // Straps and protection
    input wire logic strap_select_high_i,
    input wire logic strap_select_mid_i,
    input wire logic strap_select_low_i,
    input wire logic wp_i,
    // Bus
    sep_if.dev bus,
    // Status
    output logic wr_busy_o,
    output logic standby_o
);
    logic [6:0] pin_s;
    logic scl_s;
    logic sda_s;
    logic wp_s;
    logic [2:0] strap_s;
    logic done_tgl_s;
    logic req_tgl_s;
    logic scl_q_r;
    logic sda_q_r;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic active;
    logic pb_we;
    sep_pkg::sep_dst_t st_r;
    logic [3:0] cnt_r;
    logic [7:0] sh_r;
    logic [7:0] tx_r;
    logic sda_oe_r;
    logic [sep_pkg::ADDR_W-1:0] addr_r;
    logic [sep_pkg::PAGE_BYTES-1:0] pval_r;
    logic mack_r;
    logic first_r;
    logic commit_go_r;
    logic wr_pend_r;
    logic copying_r;
    logic [4:0] cp_idx_r;
    logic req_tgl_r;
    logic done_q_r;
    logic req_q_r;
    logic busy_r;
    logic done_tgl_r;
    logic [19:0] tmr_r;
    logic [7:0] pbuf [sep_pkg::PAGE_BYTES];
    // Blank cells read as all ones, so a read past written data never
    // drives unknown levels onto the shared data line.
    logic [7:0] mem [sep_pkg::MEM_BYTES] = '{default: 8'hff};

    sep_sync #(.W(7)) u_link_sync (
        .clk_i(link_clk_i),
        .rst_b_i(rst_b_i),
        .d_i({bus.scl, bus.sda, wp_i, strap_select_high_i,
              strap_select_mid_i, strap_select_low_i, done_tgl_r}),
        .q_o(pin_s)
    );

    sep_sync #(.W(1)) u_sys_sync (
        .clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .d_i(req_tgl_r),
        .q_o(req_tgl_s)
    );

    assign scl_s = pin_s[6];
    assign sda_s = pin_s[5];
    assign wp_s = pin_s[4];
    assign strap_s = pin_s[3:1];
    assign done_tgl_s = pin_s[0];
    assign scl_rise = scl_s & ~scl_q_r;
    assign scl_fall = ~scl_s & scl_q_r;
    assign start_det = scl_s & scl_q_r & sda_q_r & ~sda_s;
    assign stop_det = scl_s & scl_q_r & ~sda_q_r & sda_s;
    assign active = ~wr_pend_r & ~commit_go_r & ~start_det & ~stop_det;
    assign pb_we = active & scl_fall & (cnt_r == sep_pkg::BIT_ACK)
                   & (st_r == sep_pkg::SD_WDATA);
    assign bus.sda_d_oe = sda_oe_r;

    always_ff @(posedge link_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            scl_q_r <= 1'b0;
            sda_q_r <= 1'b0;
        end else begin
            scl_q_r <= scl_s;
            sda_q_r <= sda_s;
        end
    end

    always_ff @(posedge link_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_r <= sep_pkg::SD_IDLE;
            cnt_r <= 4'h0;
            sh_r <= 8'h00;
            tx_r <= 8'h00;
            sda_oe_r <= 1'b0;
            addr_r <= '0;
            pval_r <= '0;
            mack_r <= 1'b0;
            first_r <= 1'b0;
            commit_go_r <= 1'b0;
        end else begin
            commit_go_r <= 1'b0;
            if (wr_pend_r || commit_go_r) begin
                st_r <= sep_pkg::SD_IDLE;
                sda_oe_r <= 1'b0;
                cnt_r <= 4'h0;
            end else if (start_det) begin
                st_r <= sep_pkg::SD_DEV;
                sda_oe_r <= 1'b0;
                cnt_r <= 4'h0;
            end else if (stop_det) begin
                st_r <= sep_pkg::SD_IDLE;
                sda_oe_r <= 1'b0;
                if (st_r == sep_pkg::SD_WDATA && |pval_r &&
                    !(wp_s && addr_r[12:11] == sep_pkg::WP_QUADRANT)) begin
                    commit_go_r <= 1'b1;
                end
            end else if (st_r != sep_pkg::SD_IDLE) begin
                if (scl_rise) begin
                    cnt_r <= cnt_r + 4'h1;
                    if (cnt_r < sep_pkg::BIT_ACK) begin
                        sh_r <= {sh_r[6:0], sda_s};
                    end else begin
                        mack_r <= sda_s;
                    end
                end
                if (scl_fall && cnt_r == sep_pkg::BIT_ACK) begin
                    unique case (st_r)
                        sep_pkg::SD_DEV: begin
                            // Polling NACK comes from the guard above.
                            if (sh_r[7:4] == sep_pkg::DEV_TYPE_ID &&
                                sh_r[3:1] == strap_s) begin
                                sda_oe_r <= 1'b1;
                                first_r <= 1'b1;
                                st_r <= sh_r[0] ? sep_pkg::SD_RDATA
                                                : sep_pkg::SD_WHI;
                            end else begin
                                st_r <= sep_pkg::SD_IGN;
                            end
                        end
                        sep_pkg::SD_WHI: begin
                            addr_r[12:sep_pkg::WADDR_HI_LSB] <= sh_r[4:0];
                            sda_oe_r <= 1'b1;
                            st_r <= sep_pkg::SD_WLO;
                        end
                        sep_pkg::SD_WLO: begin
                            addr_r[7:0] <= sh_r;
                            sda_oe_r <= 1'b1;
                            pval_r <= '0;
                            st_r <= sep_pkg::SD_WDATA;
                        end
                        sep_pkg::SD_WDATA: begin
                            sda_oe_r <= 1'b1;
                            pval_r[addr_r[4:0]] <= 1'b1;
                            addr_r[4:0] <= addr_r[4:0] + 5'h01;
                        end
                        sep_pkg::SD_RDATA: begin
                            sda_oe_r <= 1'b0;
                        end
                        default: begin
                            sda_oe_r <= 1'b0;
                        end
                    endcase
                end else if (scl_fall && cnt_r == sep_pkg::BIT_END) begin
                    cnt_r <= 4'h0;
                    first_r <= 1'b0;
                    if (st_r == sep_pkg::SD_RDATA && (first_r || !mack_r)) begin
                        sda_oe_r <= ~mem[addr_r][7];
                        tx_r <= {mem[addr_r][6:0], 1'b0};
                        addr_r <= addr_r + 13'h0001;
                    end else begin
                        sda_oe_r <= 1'b0;
                        if (st_r == sep_pkg::SD_RDATA) begin
                            st_r <= sep_pkg::SD_IGN;
                        end
                    end
                end else if (scl_fall && st_r == sep_pkg::SD_RDATA &&
                             cnt_r != 4'h0) begin
                    sda_oe_r <= ~tx_r[7];
                    tx_r <= {tx_r[6:0], 1'b0};
                end
            end
        end
    end

    always_ff @(posedge link_clk_i) begin
        if (pb_we) begin
            pbuf[addr_r[4:0]] <= sh_r;
        end
    end

    // Row and column form the address.
    always_ff @(posedge link_clk_i) begin
        if (copying_r && pval_r[cp_idx_r]) begin
            mem[{addr_r[12:sep_pkg::ROW_LSB], cp_idx_r}] <= pbuf[cp_idx_r];
        end
    end

    // The page is copied over 32 link cycles; the sys-side timer sets how long the
    // device then stays deaf, which is what the bus can observe.
    always_ff @(posedge link_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_pend_r <= 1'b0;
            copying_r <= 1'b0;
            cp_idx_r <= 5'h00;
            req_tgl_r <= 1'b0;
            done_q_r <= 1'b0;
        end else begin
            done_q_r <= done_tgl_s;
            if (commit_go_r) begin
                wr_pend_r <= 1'b1;
                copying_r <= 1'b1;
                cp_idx_r <= 5'h00;
                req_tgl_r <= ~req_tgl_r;
            end else begin
                if (copying_r) begin
                    cp_idx_r <= cp_idx_r + 5'h01;
                    if (cp_idx_r == 5'h1f) begin
                        copying_r <= 1'b0;
                    end
                end
                if (done_tgl_s != done_q_r) begin
                    wr_pend_r <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge link_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            standby_o <= 1'b1;
        end else begin
            standby_o <= (st_r == sep_pkg::SD_IDLE) & ~wr_pend_r;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            req_q_r <= 1'b0;
            busy_r <= 1'b0;
            done_tgl_r <= 1'b0;
            tmr_r <= 20'h00000;
            wr_busy_o <= 1'b0;
        end else begin
            req_q_r <= req_tgl_s;
            wr_busy_o <= busy_r;
            if (req_tgl_s != req_q_r) begin
                busy_r <= 1'b1;
                tmr_r <= 20'(WR_CYCLES - 1);
            end else if (busy_r) begin
                if (tmr_r == 20'h00000) begin
                    busy_r <= 1'b0;
                    done_tgl_r <= ~done_tgl_r;
                end else begin
                    tmr_r <= tmr_r - 20'h00001;
                end
            end
        end
    end
endmodule : sep_dev

// ### sep_pkg.sv
// Purpose: Shared constants and types for the serial EEPROM link ends.
// Assumes: System clock of 200 MHz, 400 kHz bus clock from the master.
// Notes: All timing counts derive from times held in their own units.
package sep_pkg;

    localparam int SYS_PERIOD_NS = 5;
    localparam int SCL_PERIOD_NS = 2500;
    localparam int SCL_QTR_CYC = SCL_PERIOD_NS / (4 * SYS_PERIOD_NS);
    localparam int WRITE_CYCLE_TIME_NS = 5000000;
    localparam int WR_CYCLES = WRITE_CYCLE_TIME_NS / SYS_PERIOD_NS;
    localparam int RECOV_MAX_CLK = 9;

    localparam logic [3:0] DEV_TYPE_ID = 4'ha;
    localparam int ADDR_W = 13;
    localparam int PAGE_BYTES = 32;
    localparam int PAGE_COUNT = 256;
    localparam int MEM_BYTES = PAGE_BYTES * PAGE_COUNT;
    localparam int WADDR_HI_LSB = 8;
    localparam int ROW_LSB = 5;
    localparam logic [1:0] WP_QUADRANT = 2'h3;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [3:0] BIT_END = 4'h9;

    typedef enum logic [2:0] {
        SEP_CMD_START,
        SEP_CMD_STOP,
        SEP_CMD_WRITE,
        SEP_CMD_READ,
        SEP_CMD_RECOVER
    } sep_cmd_t;

    typedef enum logic [2:0] {
        SD_IDLE,
        SD_DEV,
        SD_WHI,
        SD_WLO,
        SD_WDATA,
        SD_RDATA,
        SD_IGN
    } sep_dst_t;

    typedef enum logic [2:0] {
        SM_IDLE,
        SM_START,
        SM_BIT,
        SM_STOP,
        SM_RECOV
    } sep_mst_t;

endpackage : sep_pkg

// ### sep_if.sv
// Purpose: Two-wire bus between the master end and the EEPROM end.
// Assumes: Both lines are open drain with a pull-up to high.
// Notes: Each party only ever pulls a line low, so outputs are implied 0.
`timescale 1ns/1ps
interface sep_if;
    logic scl_m_oe;
    logic sda_m_oe;
    logic sda_d_oe;
    logic scl;
    logic sda;

    // Wired-AND of the open-drain drivers with the pull-ups.
    assign scl = ~scl_m_oe;
    assign sda = ~(sda_m_oe | sda_d_oe);

    modport mst (output scl_m_oe, output sda_m_oe, input sda);
    modport dev (output sda_d_oe, input scl, input sda);
endinterface : sep_if

// ### sep_sync.sv
// Purpose: Two flip-flop synchroniser for a vector of levels.
// Assumes: Each bit is an independent level.
// Notes: The first stage is read only by the second stage.
`timescale 1ns/1ps
module sep_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Data
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_r <= '0;
            q_o <= '0;
        end else begin
            meta_r <= d_i;
            q_o <= meta_r;
        end
    end
endmodule : sep_sync

// ### sep_mst.sv
// Purpose: Byte-level two-wire bus master with clock recovery.
// Assumes: No clock stretching by the slave.
// Notes: SCL is a divided copy of sys_clk_i, four quarters per bit.
`timescale 1ns/1ps
module sep_mst (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // Command port
    input wire logic cmd_valid_i,
    input wire sep_pkg::sep_cmd_t cmd_i,
    input wire logic [7:0] wdata_i,
    input wire logic rd_nack_i,
    output logic cmd_ready_o,
    output logic done_o,
    output logic [7:0] rdata_o,
    output logic ack_o,
    // Bus
    sep_if.mst bus
);
    logic sda_s;
    logic tick;
    logic [8:0] rx_nxt;
    sep_pkg::sep_mst_t st_r;
    logic [6:0] qcnt_r;
    logic [1:0] ph_r;
    logic [3:0] bit_r;
    logic [8:0] tx_r;
    logic [8:0] rx_r;
    logic scl_oe_r;
    logic sda_oe_r;

    sep_sync #(.W(1)) u_sda_sync (
        .clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .d_i(bus.sda),
        .q_o(sda_s)
    );

    assign tick = (qcnt_r == 7'(sep_pkg::SCL_QTR_CYC - 1));
    assign rx_nxt = {rx_r[7:0], sda_s};
    assign bus.scl_m_oe = scl_oe_r;
    assign bus.sda_m_oe = sda_oe_r;

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            qcnt_r <= 7'h00;
        end else if (st_r == sep_pkg::SM_IDLE || tick) begin
            qcnt_r <= 7'h00;
        end else begin
            qcnt_r <= qcnt_r + 7'h01;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_r <= sep_pkg::SM_IDLE;
            ph_r <= 2'h0;
            bit_r <= 4'h0;
            tx_r <= 9'h1ff;
            rx_r <= 9'h000;
            scl_oe_r <= 1'b0;
            sda_oe_r <= 1'b0;
            cmd_ready_o <= 1'b1;
            done_o <= 1'b0;
            rdata_o <= 8'h00;
            ack_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (st_r == sep_pkg::SM_IDLE) begin
                if (cmd_valid_i) begin
                    cmd_ready_o <= 1'b0;
                    ph_r <= 2'h0;
                    bit_r <= 4'h0;
                    unique case (cmd_i)
                        sep_pkg::SEP_CMD_START: st_r <= sep_pkg::SM_START;
                        sep_pkg::SEP_CMD_STOP: st_r <= sep_pkg::SM_STOP;
                        sep_pkg::SEP_CMD_WRITE: begin
                            tx_r <= {wdata_i, 1'b1};
                            st_r <= sep_pkg::SM_BIT;
                        end
                        sep_pkg::SEP_CMD_READ: begin
                            // Send 1 to end a read.
                            tx_r <= {8'hff, rd_nack_i};
                            st_r <= sep_pkg::SM_BIT;
                        end
                        sep_pkg::SEP_CMD_RECOVER: begin
                            tx_r <= 9'h1ff;
                            st_r <= sep_pkg::SM_RECOV;
                        end
                        default: st_r <= sep_pkg::SM_IDLE;
                    endcase
                end
            end else if (tick) begin
                ph_r <= ph_r + 2'h1;
                unique case (ph_r)
                    2'h0: scl_oe_r <= 1'b1;
                    2'h1: begin
                        unique case (st_r)
                            sep_pkg::SM_START: sda_oe_r <= 1'b0;
                            sep_pkg::SM_STOP: sda_oe_r <= 1'b1;
                            default: sda_oe_r <= ~tx_r[8];
                        endcase
                    end
                    2'h2: scl_oe_r <= 1'b0;
                    default: begin
                        unique case (st_r)
                            sep_pkg::SM_START: begin
                                sda_oe_r <= 1'b1;
                                st_r <= sep_pkg::SM_IDLE;
                                cmd_ready_o <= 1'b1;
                                done_o <= 1'b1;
                            end
                            sep_pkg::SM_STOP: begin
                                sda_oe_r <= 1'b0;
                                st_r <= sep_pkg::SM_IDLE;
                                cmd_ready_o <= 1'b1;
                                done_o <= 1'b1;
                            end
                            sep_pkg::SM_RECOV: begin
                                bit_r <= bit_r + 4'h1;
                                // Clock until data high or nine clocks, then Start.
                                if (sda_s || bit_r ==
                                    4'(sep_pkg::RECOV_MAX_CLK - 1)) begin
                                    st_r <= sep_pkg::SM_START;
                                end
                            end
                            default: begin
                                rx_r <= rx_nxt;
                                tx_r <= {tx_r[7:0], 1'b1};
                                bit_r <= bit_r + 4'h1;
                                if (bit_r == sep_pkg::BIT_ACK) begin
                                    rdata_o <= rx_nxt[8:1];
                                    ack_o <= ~rx_nxt[0];
                                    st_r <= sep_pkg::SM_IDLE;
                                    cmd_ready_o <= 1'b1;
                                    done_o <= 1'b1;
                                end
                            end
                        endcase
                    end
                endcase
            end
        end
    end
endmodule : sep_mst

// ### sep_link_checker.sv
// Purpose: Watches the shared two-wire lines and the write timer.
// Assumes: Sampled on the system clock, far faster than the bus clock.
// Notes: Device drive changes land a few link cycles after SCL falls.
`timescale 1ns/1ps
module sep_link_checker #(
    parameter int WR_CYCLES = 8000
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // Bus lines
    input wire logic scl_m_oe,
    input wire logic sda_m_oe,
    input wire logic sda_d_oe,
    input wire logic scl,
    input wire logic sda,
    // Device status
    input wire logic wr_busy_o,
    input wire logic standby_o
);
    logic scl_q_r;
    logic [3:0] hold_r;
    logic [31:0] busy_r;
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_b_i);
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) scl_q_r <= 1'b1;
        else scl_q_r <= scl;
    end
    // Counts SCL rises while the device holds SDA without a break.
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i || !sda_d_oe) hold_r <= 4'h0;
        else if (scl && !scl_q_r && hold_r != 4'hf) hold_r <= hold_r + 4'h1;
    end
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i || !wr_busy_o) busy_r <= 32'h0;
        else busy_r <= busy_r + 32'h1;
    end
    a_dev_stable_high: assert property (scl && $past(scl) |->
        $stable(sda_d_oe)) else $error("device SDA moved while SCL high");
    a_no_contend: assert property (sda_d_oe && scl |-> !sda_m_oe)
        else $error("both parties drive SDA in high phase");
    a_busy_deaf: assert property (wr_busy_o |-> !sda_d_oe)
        else $error("device drives SDA during write cycle");
    a_busy_awake: assert property (wr_busy_o |-> !standby_o)
        else $error("standby shown during write cycle");
    a_busy_len: assert property ($fell(wr_busy_o) |->
        busy_r >= WR_CYCLES - 4 && busy_r <= WR_CYCLES + 4)
        else $error("write cycle length wrong");
    a_recov_nine: assert property (hold_r <= 4'h9)
        else $error("device held SDA over nine clocks");
    a_start_wake: assert property (scl && $past(scl) && $fell(sda) &&
        standby_o && !wr_busy_o |-> ##[1:40] !standby_o)
        else $error("start did not leave standby");
    a_stop_release: assert property (scl && $past(scl) && $rose(sda)
        |=> !sda_d_oe [*4]) else $error("device drives SDA after stop");
    c_write_done: cover property ($fell(wr_busy_o));
    c_dev_drive: cover property (sda_d_oe && scl);
    c_standby: cover property ($rose(standby_o));
endmodule : sep_link_checker

// ### serial_eeprom_addr_write_slave_tb.sv
// Purpose: Random and corner stimulus for both ends of the serial link.
// Assumes: Write timer shortened so the whole run stays short.
// Notes: Expected bytes are the bench's own copies of what it sent.
`timescale 1ns/1ps
module serial_eeprom_addr_write_slave_tb;
    localparam int WR = 8000;
    localparam sep_pkg::sep_cmd_t CS = sep_pkg::SEP_CMD_START;
    localparam sep_pkg::sep_cmd_t CP = sep_pkg::SEP_CMD_STOP;
    logic sys_clk_i = 1'b0;
    logic link_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [2:0] strap = 3'h0;
    logic wp_i = 1'b0;
    logic cmd_valid_i = 1'b0;
    sep_pkg::sep_cmd_t cmd_i = CS;
    logic [7:0] wdata_i = 8'h00;
    logic rd_nack_i = 1'b0;
    logic cmd_ready_o, done_o, ack_o, wr_busy_o, standby_o;
    logic [7:0] rdata_o, aw, hi, lo, d0, d1, d2, m;
    logic [31:0] seed = 32'hf701;
    int err_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    sep_if bus();
    sep_mst i_sep_mst(.sys_clk_i, .rst_b_i, .cmd_valid_i, .cmd_i, .wdata_i,
        .rd_nack_i, .cmd_ready_o, .done_o, .rdata_o, .ack_o, .bus);
    sep_dev #(.WR_CYCLES(WR)) i_sep_dev(.sys_clk_i, .link_clk_i, .rst_b_i,
        .strap_select_high_i(strap[2]), .strap_select_mid_i(strap[1]),
        .strap_select_low_i(strap[0]), .wp_i, .bus, .wr_busy_o, .standby_o);
    sep_link_checker #(.WR_CYCLES(WR)) i_sep_link_checker(.sys_clk_i,
        .rst_b_i, .scl_m_oe(bus.scl_m_oe), .sda_m_oe(bus.sda_m_oe),
        .sda_d_oe(bus.sda_d_oe), .scl(bus.scl), .sda(bus.sda), .wr_busy_o,
        .standby_o);
    initial begin
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end
    // Odd offset keeps the link clock out of phase with the system clock.
    initial begin
        #1.3;
        forever #7.5 link_clk_i = ~link_clk_i;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs
    function automatic logic exp_ack(input logic [7:0] a);
        return a[7:4] == 4'ha && a[3:1] == strap;
    endfunction : exp_ack
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic run(input sep_pkg::sep_cmd_t c, input logic [7:0] d,
        input logic nk);
        int n;
        n = 0;
        @(posedge sys_clk_i);
        #1;
        cmd_i = c;
        wdata_i = d;
        rd_nack_i = nk;
        cmd_valid_i = 1'b1;
        @(posedge sys_clk_i);
        #1;
        cmd_valid_i = 1'b0;
        while (done_o !== 1'b1 && n < 6000) begin
            @(posedge sys_clk_i);
            #1;
            n++;
        end
        chk({7'h0, done_o}, 8'h01);
    endtask : run
    task automatic wb(input logic [7:0] d, input logic e);
        run(sep_pkg::SEP_CMD_WRITE, d, 1'b0);
        chk({7'h0, ack_o}, {7'h0, e});
    endtask : wb
    task automatic rd(input logic nk, input logic [7:0] e);
        run(sep_pkg::SEP_CMD_READ, 8'h00, nk);
        chk(rdata_o, e);
    endtask : rd
    task automatic settle();
        int n;
        n = 0;
        while (standby_o !== 1'b1 && n < 12000) begin
            @(posedge sys_clk_i);
            #1;
            n++;
        end
        chk({6'h0, wr_busy_o, standby_o}, 8'h01);
    endtask : settle
    task automatic tally_and_finish();
        $display("compares=%0d mismatches=%0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 110000) begin
            err_count++;
            tally_and_finish();
        end
    end
    initial begin
        seed = xs(seed);
        strap = seed[2:0];
        repeat (3) @(posedge sys_clk_i);
        #1;
        rst_b_i = 1'b1;
        repeat (4) @(posedge link_clk_i);
        settle();
        m = {4'hb, strap, 1'b0};
        run(CS, 8'h00, 1'b0);
        wb(m, exp_ack(m));
        seed = xs(seed);
        m = {4'ha, strap ^ {seed[1:0], ~|seed[1:0]}, 1'b0};
        run(CS, 8'h00, 1'b0);
        wb(m, exp_ack(m));
        aw = {4'ha, strap, 1'b0};
        hi = seed[15:8];
        lo = {seed[18:16], 5'h1e};
        seed = xs(seed);
        {d0, d1, d2} = seed[23:0];
        // Start two bytes before the page end so the third wraps.
        run(CS, 8'h00, 1'b0);
        wb(aw, exp_ack(aw));
        wb(hi, 1'b1);
        wb(lo, 1'b1);
        wb(d0, 1'b1);
        wb(d1, 1'b1);
        wb(d2, 1'b1);
        run(CP, 8'h00, 1'b0);
        run(CS, 8'h00, 1'b0);
        wb(aw, 1'b0);
        run(CP, 8'h00, 1'b0);
        settle();
        run(CS, 8'h00, 1'b0);
        wb(aw, 1'b1);
        wb(hi, 1'b1);
        wb(lo, 1'b1);
        run(CS, 8'h00, 1'b0);
        wb(aw | 8'h01, 1'b1);
        rd(1'b0, d0);
        rd(1'b0, d1);
        run(sep_pkg::SEP_CMD_RECOVER, 8'h00, 1'b0);
        wb(aw, 1'b1);
        wb(hi, 1'b1);
        wb({lo[7:5], 5'h00}, 1'b1);
        run(CS, 8'h00, 1'b0);
        wb(aw | 8'h01, 1'b1);
        rd(1'b1, d2);
        run(CP, 8'h00, 1'b0);
        settle();
        tally_and_finish();
    end
endmodule : serial_eeprom_addr_write_slave_tb
